// file: verilog/sfm_pkg.sv
// Constants, states and helpers for the serial format and mode unit.
// Assumes one 100 MHz clock and a byte-wide register port.
package sfm_pkg;
  // Register indices on the 3-bit address port
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_BAUD = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_TXH = 3'h3;
  localparam logic [2:0] ADDR_STAT = 3'h4;
  localparam logic [2:0] ADDR_RXH = 3'h5;
  localparam logic [2:0] ADDR_FMT = 3'h6;
  // serial_mode_reg fields
  localparam int MODE_SYNC = 7;
  localparam int MODE_CHR7 = 6;
  localparam int MODE_PAR = 5;
  localparam int MODE_ODD = 4;
  localparam int MODE_STOP2 = 3;
  localparam int MODE_MP = 2;
  // serial_control_reg fields
  localparam int CTRL_TXEN = 5;
  localparam int CTRL_RXEN = 4;
  localparam int CTRL_CKHI = 1;
  localparam int CTRL_CKLO = 0;
  // Status fields
  localparam int ST_TDRE = 7;
  localparam int ST_RDRF = 6;
  localparam int ST_OVERRUN_ERROR_FLAG = 5;
  localparam int ST_FER = 4;
  localparam int ST_PER = 3;
  localparam int ST_TEND = 2;
  localparam int ST_MPBR = 1;
  localparam int ST_MPBT = 0;
  localparam int ST_BRK = 3;
  // serial_format_ctrl fields and values
  localparam int FMT_ORDER = 3;
  localparam int FMT_INV = 2;
  localparam int FMT_IFSEL = 0;
  localparam logic [7:0] FMT_RESET = 8'hF2;
  localparam logic [7:0] FMT_ONES = 8'hF2;
  localparam logic [7:0] FMT_WMASK = 8'h0D;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'hFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Oversampling: 16 ticks a bit, sample on the 8th
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [2:0] SCK_HALF = 3'h7;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} sfm_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} sfm_rx_t;

  // Maps data bits to line order (bit i = i-th bit on the line); self-inverse
  function automatic logic [7:0] sfm_order(input logic [7:0] d, input logic len7,
                                           input logic msb);
    logic [7:0] r;
    r = d;
    if (msb)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (len7)
          r[i] = (i < 7) ? d[6-i] : 1'b0;
        else
          r[i] = d[7-i];
      end
    end
    return r;
  endfunction : sfm_order
endpackage : sfm_pkg

// file: verilog/sfm_baud_gen.sv
// Baud-rate generator: prescaler (1, 4, 16, 64) then divide by divisor+1.
// Assumes run is held while the internal clock source is in use.
`timescale 1ns/1ps
module sfm_baud_gen
  import sfm_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  input wire logic mclk, // System clock
  input wire logic rst, // Asynchronous reset
  input wire logic run, // Generator enabled
  input wire logic [1:0] prescale, // 0:/1 1:/4 2:/16 3:/64
  input wire logic [DIV_W-1:0] divisor, // Divide by divisor+1
  output logic tick // One-cycle enable pulse
);
  typedef struct packed {
    logic [5:0] pre;
    logic [DIV_W-1:0] cnt;
    logic tick;
  } sfm_brg_t;

  sfm_brg_t s_reg;
  sfm_brg_t s_next;
  logic [5:0] mask;
  logic pre_en;

  always_comb
  begin
    s_next = s_reg;
    case (prescale)
      2'd0: mask = 6'h00;
      2'd1: mask = 6'h03;
      2'd2: mask = 6'h0F;
      default: mask = 6'h3F;
    endcase
    pre_en = ((s_reg.pre & mask) == mask);
    s_next.tick = 1'b0;
    if (!run)
    begin
      s_next.pre = '0;
      s_next.cnt = '0;
    end
    else
    begin
      s_next.pre = pre_en ? 6'h00 : s_reg.pre + 6'h01;
      if (pre_en)
      begin
        if (s_reg.cnt >= divisor)
        begin
          s_next.cnt = '0;
          s_next.tick = 1'b1;
        end
        else
          s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tick = s_reg.tick;
endmodule : sfm_baud_gen

// file: verilog/sfm_serial_format.sv
// Serial unit: mode, frame format, clock source, tx/rx shifters and flags.
// Assumes rxd and sck_in are synchronous to mclk; software keeps its own duties.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module sfm_serial_format
  import sfm_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst, // Asynchronous reset
  input wire logic standby, // Standby mode entered
  input wire logic [2:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic rxd, // Serial receive line
  output logic txd, // Serial transmit line
  input wire logic sck_in, // Clock pin input level
  output logic sck_out, // Clock pin output level
  output logic sck_oe // Clock pin output enable
);
  typedef struct packed {
    logic [7:0] serial_mode_reg;
    logic [7:0] brr;
    logic [7:0] serial_control_reg;
    logic [7:0] transmit_holding_reg;
    logic [7:0] receive_holding_reg;
    logic [7:0] fmt;
    logic [7:0] rdata;
    logic tdre;
    logic rdrf;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic per;
    logic brk;
    logic mpbt;
    logic mpbr;
    sfm_tx_t tx_st;
    logic [7:0] tx_sh;
    logic tx_par;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic tx_stop;
    logic txd;
    sfm_rx_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic rx_par;
    logic sck;
    logic sck_prev;
    logic [2:0] sck_div;
  } sfm_state_t;

  sfm_state_t s;
  sfm_state_t n;
  logic brg_tick;
  logic brg_run;
  logic sync_m;
  logic ext_clk;
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic s_fall;
  logic s_rise;
  logic len7;
  logic par_on;
  logic mp_on;
  logic [2:0] last_bit;
  logic [7:0] ld_bits;
  logic do_store;
  logic [7:0] st_data;
  logic [7:0] fmt_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and frame shape
  assign sync_m = s.serial_mode_reg[MODE_SYNC];
  assign ext_clk = s.serial_control_reg[CTRL_CKHI];
  assign len7 = ~sync_m & s.serial_mode_reg[MODE_CHR7];
  assign mp_on = ~sync_m & s.serial_mode_reg[MODE_MP];
  assign par_on = ~sync_m & ~s.serial_mode_reg[MODE_MP] & s.serial_mode_reg[MODE_PAR];
  assign last_bit = len7 ? 3'd6 : 3'd7;
  assign brg_run = ~ext_clk & (s.serial_control_reg[CTRL_TXEN] | s.serial_control_reg[CTRL_RXEN]);
  assign ext_rise = sck_in & ~s.sck_prev;
  assign ext_fall = ~sck_in & s.sck_prev;
  assign tick = ext_clk ? ext_rise : brg_tick;
  assign s_fall = ext_clk ? ext_fall : (brg_tick & s.sck);
  assign s_rise = ext_clk ? ext_rise : (brg_tick & ~s.sck);
  assign fmt_rd = FMT_ONES | (s.fmt & FMT_WMASK);
  // Invert then reorder outgoing data
  assign ld_bits = sfm_order(s.fmt[FMT_INV] ? ~s.transmit_holding_reg : s.transmit_holding_reg, len7,
                             s.fmt[FMT_ORDER]);

  sfm_baud_gen #(
    .DIV_W(8)
  ) u_brg (
    .mclk(mclk),
    .rst(rst),
    .run(brg_run),
    .prescale(s.serial_mode_reg[1:0]),
    .divisor(s.brr),
    .tick(brg_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    n = s;
    do_store = 1'b0;
    n.sck_prev = sck_in;
    n.rdata = 8'h00;
    // Register reads
    if (rd)
    begin
      case (addr)
        ADDR_MODE: n.rdata = s.serial_mode_reg;
        ADDR_BAUD: n.rdata = s.brr;
        ADDR_CTRL: n.rdata = s.serial_control_reg;
        ADDR_TXH: n.rdata = s.transmit_holding_reg;
        ADDR_STAT: n.rdata = {s.tdre, s.rdrf, s.overrun_error_flag, s.framing_error_flag, s.per | s.brk,
                              s.tdre & (s.tx_st == TX_IDLE), s.mpbr, s.mpbt};
        ADDR_RXH: n.rdata = s.receive_holding_reg;
        ADDR_FMT: n.rdata = fmt_rd;
        default: n.rdata = 8'h00;
      endcase
    end
    // Register writes; flag clears come first so hardware sets win
    if (wr)
    begin
      case (addr)
        ADDR_MODE: n.serial_mode_reg = wdata;
        ADDR_BAUD: n.brr = wdata;
        ADDR_CTRL: n.serial_control_reg = wdata;
        ADDR_TXH:
        begin
          n.transmit_holding_reg = wdata;
          n.tdre = 1'b0;
        end
        ADDR_STAT:
        begin
          if (wdata[ST_RDRF]) n.rdrf = 1'b0;
          if (wdata[ST_OVERRUN_ERROR_FLAG]) n.overrun_error_flag = 1'b0;
          if (wdata[ST_FER]) n.framing_error_flag = 1'b0;
          if (wdata[ST_PER])
          begin
            n.per = 1'b0;
            n.brk = 1'b0;
          end
          n.mpbt = wdata[ST_MPBT];
        end
        ADDR_FMT: n.fmt = (s.fmt & ~FMT_WMASK) | (wdata & FMT_WMASK);
        default: n.fmt = s.fmt;
      endcase
    end
    if (standby)
      n.fmt = FMT_RESET;

    if (!sync_m)
    begin
      //////////////////////////////////////////////////////////////////////
      // Asynchronous clock pin: bit-rate output when enables are 0/1
      if (!ext_clk && s.serial_control_reg[CTRL_CKLO] && tick)
      begin
        n.sck_div = s.sck_div + 3'd1;
        if (s.sck_div == SCK_HALF) n.sck = ~s.sck;
      end
      // Transmitter
      case (s.tx_st)
        TX_IDLE:
        begin
          n.txd = 1'b1;
          if (s.serial_control_reg[CTRL_TXEN] && !s.tdre && tick)
          begin
            n.tx_sh = ld_bits;
            // Unsent eighth bit of a 7-bit character stays out of parity
            n.tx_par = mp_on ? s.mpbt :
                       ((^(ld_bits & {~len7, 7'h7F})) ^ s.serial_mode_reg[MODE_ODD]);
            n.tdre = 1'b1;
            n.tx_st = TX_START;
            n.tx_cnt = 4'h0;
            n.tx_bit = 3'd0;
            n.txd = 1'b0;
          end
        end
        TX_START, TX_DATA, TX_PAR, TX_STOP:
        begin
          if (tick)
          begin
            n.tx_cnt = s.tx_cnt + 4'h1;
            if (s.tx_cnt == OVS_LAST)
            begin
              case (s.tx_st)
                TX_START:
                begin
                  n.tx_st = TX_DATA;
                  n.txd = s.tx_sh[0];
                end
                TX_DATA:
                begin
                  if (s.tx_bit != last_bit)
                  begin
                    n.tx_bit = s.tx_bit + 3'd1;
                    n.txd = s.tx_sh[n.tx_bit];
                  end
                  else if (par_on || mp_on)
                  begin
                    n.tx_st = TX_PAR;
                    n.txd = s.tx_par;
                  end
                  else
                  begin
                    n.tx_st = TX_STOP;
                    n.tx_stop = s.serial_mode_reg[MODE_STOP2];
                    n.txd = 1'b1;
                  end
                end
                TX_PAR:
                begin
                  n.tx_st = TX_STOP;
                  n.tx_stop = s.serial_mode_reg[MODE_STOP2];
                  n.txd = 1'b1;
                end
                default:
                begin
                  n.tx_stop = 1'b0;
                  if (!s.tx_stop) n.tx_st = TX_IDLE;
                end
              endcase
            end
          end
        end
        default: n.tx_st = TX_IDLE;
      endcase
      // Receiver, 16x oversampled
      if (tick)
      begin
        case (s.rx_st)
          RX_IDLE:
          begin
            if (s.serial_control_reg[CTRL_RXEN] && !rxd)
            begin
              n.rx_st = RX_START;
              n.rx_cnt = 4'h0;
              n.rx_sh = 8'h00;
              n.rx_bit = 3'd0;
            end
          end
          RX_START:
          begin
            n.rx_cnt = s.rx_cnt + 4'h1;
            if (s.rx_cnt == OVS_MID)
            begin
              n.rx_cnt = 4'h0;
              n.rx_st = rxd ? RX_IDLE : RX_DATA;
            end
          end
          default:
          begin
            n.rx_cnt = s.rx_cnt + 4'h1;
            if (s.rx_cnt == OVS_LAST)
            begin
              case (s.rx_st)
                RX_DATA:
                begin
                  n.rx_sh[s.rx_bit] = rxd;
                  n.rx_bit = s.rx_bit + 3'd1;
                  if (s.rx_bit == last_bit)
                    n.rx_st = (par_on || mp_on) ? RX_PAR : RX_STOP;
                end
                RX_PAR:
                begin
                  n.rx_par = rxd;
                  n.rx_st = RX_STOP;
                end
                default:
                begin
                  n.rx_st = RX_IDLE;
                  do_store = 1'b1;
                  n.framing_error_flag = s.framing_error_flag | ~rxd;
                  n.brk = s.brk | (~rxd & (s.rx_sh == 8'h00) & ~s.rx_par);
                  if (par_on && (s.rx_par != ((^s.rx_sh) ^ s.serial_mode_reg[MODE_ODD])))
                    n.per = 1'b1;
                  if (mp_on) n.mpbr = s.rx_par;
                end
              endcase
            end
          end
        endcase
      end
    end
    else
    begin
      //////////////////////////////////////////////////////////////////////
      // Clocked mode: 8 bits, no extras, clock idles high
      if (s.tx_st == TX_IDLE)
      begin
        n.sck = 1'b1;
        // Last bit holds through its rising clock, line returns high after
        n.txd = 1'b1;
        if ((s.serial_control_reg[CTRL_TXEN] && !s.tdre) || (s.serial_control_reg[CTRL_RXEN] && !s.serial_control_reg[CTRL_TXEN]))
        begin
          n.tx_st = TX_DATA;
          n.tx_bit = 3'd0;
          n.rx_sh = 8'h00;
          if (s.serial_control_reg[CTRL_TXEN])
          begin
            n.tx_sh = ld_bits;
            n.tdre = 1'b1;
            n.txd = ld_bits[0];
          end
        end
      end
      else
      begin
        if (!ext_clk && brg_tick) n.sck = ~s.sck;
        if (s_fall && s.serial_control_reg[CTRL_TXEN]) n.txd = s.tx_sh[s.tx_bit];
        if (s_rise)
        begin
          n.rx_sh[s.tx_bit] = rxd;
          n.tx_bit = s.tx_bit + 3'd1;
          if (s.tx_bit == 3'd7)
          begin
            n.tx_st = TX_IDLE;
            do_store = s.serial_control_reg[CTRL_RXEN];
          end
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive store: reorder, invert, or flag overrun
    st_data = sfm_order(n.rx_sh, len7, s.fmt[FMT_ORDER]);
    if (s.fmt[FMT_INV])
      st_data = len7 ? {1'b0, ~st_data[6:0]} : ~st_data;
    if (do_store)
    begin
      if (s.rdrf)
        n.overrun_error_flag = 1'b1;
      else
      begin
        n.receive_holding_reg = st_data;
        n.rdrf = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.serial_mode_reg <= MODE_RESET;
      s.brr <= BAUD_RESET;
      s.serial_control_reg <= CTRL_RESET;
      s.fmt <= FMT_RESET;
      s.tdre <= 1'b1;
      s.txd <= 1'b1;
      s.sck <= 1'b1;
      s.sck_prev <= 1'b1;
    end
    else
      s <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata = s.rdata;
  assign txd = s.txd;
  assign sck_out = s.sck;
  assign sck_oe = ~ext_clk & (sync_m | s.serial_control_reg[CTRL_CKLO]);
endmodule : sfm_serial_format

// file: verif/sfm_serial_format_props.sv
// Port checker for the serial format and mode unit.
// Assumes it is bound to sfm_serial_format and sees only its ports.
`timescale 1ns/1ps
module sfm_serial_format_props
  import sfm_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst, // Asynchronous reset
  input wire logic standby, // Standby mode
  input wire logic [2:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic rxd, // Receive line
  input wire logic txd, // Transmit line
  input wire logic sck_in, // Clock pin input
  input wire logic sck_out, // Clock pin output
  input wire logic sck_oe // Clock pin enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic sync_reg;
  logic [1:0] cke_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the sync bit and the clock-source bits
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync_reg <= 1'b0;
      cke_reg <= 2'b00;
    end
    else
    begin
      if (wr && addr == ADDR_MODE)
        sync_reg <= wdata[MODE_SYNC];
      if (wr && addr == ADDR_CTRL)
        cke_reg <= wdata[CTRL_CKHI:CTRL_CKLO];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  AST_FMT_ONES: assert property (rd && addr == ADDR_FMT |=> rdata[7:4] == 4'hF && rdata[1])
    else $error("fixed format bits not one");
  AST_FMT_WRITE: assert property ((wr && addr == ADDR_FMT && !standby) ##1
    (rd && addr == ADDR_FMT && !standby) |=> rdata == (($past(wdata, 2) & FMT_WMASK) | FMT_ONES))
    else $error("format write not read back");
  AST_FMT_STANDBY: assert property (standby ##1 (standby && rd && addr == ADDR_FMT)
    |=> rdata == FMT_RESET)
    else $error("format not reset in standby");
  AST_UNMAPPED: assert property (rd && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_SCK_OE: assert property (sck_oe == (!cke_reg[1] && (sync_reg || cke_reg[0])))
    else $error("clock pin direction wrong");
  AST_START_LEN: assert property ($fell(txd) && !sync_reg |-> (!txd)[*8])
    else $error("async low bit too short");
  AST_SYNC_HOLD: assert property (sync_reg && sck_oe && $rose(sck_out) |-> $stable(txd))
    else $error("sync data moved on rising clock");
  COV_STANDBY: cover property (standby ##1 (standby && rd && addr == ADDR_FMT));
  COV_ASYNC: cover property ($fell(txd) && !sync_reg);
  COV_SYNC: cover property (sync_reg && $rose(sck_out));
endmodule : sfm_serial_format_props

bind sfm_serial_format sfm_serial_format_props u_props (.mclk(mclk), .rst(rst),
  .standby(standby), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .rxd(rxd), .txd(txd), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe));

// file: verif/sfm_far_end.sv
// Remote serial transceiver on the line.
// Assumes bit_cyc clock cycles a bit; captures 13 line bits from a start bit.
`timescale 1ns/1ps
module sfm_far_end
(
  input wire logic mclk, // System clock
  input wire logic txd, // Line from the unit
  input wire logic listen, // Capture enable
  input wire logic [7:0] bit_cyc, // Cycles a bit
  output logic rxd, // Line into the unit
  output logic [12:0] cap_bits, // Captured line bits
  output int cap_cnt // Frames captured
);
  // Samples on falling edges, clear of the unit's updates
  initial
  begin
    rxd = 1'b1; // Mark state when idle
    cap_bits = '1;
    cap_cnt = 0;
    forever
    begin
      @(negedge mclk);
      if (listen && txd === 1'b0)
      begin
        repeat (bit_cyc / 2) @(negedge mclk);
        for (int i = 0; i < 13; i++)
        begin
          cap_bits[i] = txd;
          repeat (bit_cyc) @(negedge mclk);
        end
        cap_cnt++;
      end
    end
  end

  task automatic send(input logic [12:0] bits);
    for (int i = 0; i < 13; i++)
    begin
      @(posedge mclk);
      rxd <= bits[i]; // Whole bit times, idle high after stops
      repeat (bit_cyc - 1) @(posedge mclk);
    end
  endtask : send
endmodule : sfm_far_end

// file: verif/sfm_serial_format_tb.sv
// Self-checking bench for the serial format and mode unit.
// Assumes a far-end model on the lines and the checker bound to the unit.
`timescale 1ns/1ps
module sfm_serial_format_tb
  import sfm_pkg::*;
;
  logic mclk, rst, standby, wr, rd, sck_in, ext_run, listen, txd, rxd, sck_out, sck_oe, mpb, prev;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, bit_cyc, md, fm, d, got;
  logic [12:0] cap_bits, b, cap;
  int cap_cnt, err_count, checks_done, cyc, sp, n0, e;

  sfm_serial_format dut (.mclk(mclk), .rst(rst), .standby(standby), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe));
  sfm_far_end u_far (.mclk(mclk), .txd(txd), .listen(listen), .bit_cyc(bit_cyc),
    .rxd(rxd), .cap_bits(cap_bits), .cap_cnt(cap_cnt));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // External clock: one rising edge every two cycles
  always @(posedge mclk)
    sck_in <= ext_run ? ~sck_in : 1'b0;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc >= 60000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] x, input string m);
    checks_done++;
    if (g !== x)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk_reg
  task automatic chk_line(input logic [12:0] g, input logic [12:0] x, input string m);
    checks_done++;
    if (g !== x)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, m, g, x);
    end
  endtask : chk_line
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] g);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 g = rdata;
  endtask : rd_reg
  task automatic wr_rd(input logic [2:0] a, input logic [7:0] v, output logic [7:0] g);
    wr_reg(a, v);
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 g = rdata;
  endtask : wr_rd
  task automatic cfg(input logic [7:0] m, input logic [7:0] f, input logic [7:0] c);
    wr_reg(ADDR_CTRL, 8'h00); // Disable before changing settings
    wr_reg(ADDR_MODE, m);
    wr_reg(ADDR_BAUD, 8'h00);
    wr_reg(ADDR_FMT, f);
    wr_reg(ADDR_CTRL, c);
    #1;
  endtask : cfg
  task automatic wait_cap(input int n);
    for (int k = 0; k < 1000 && cap_cnt == n; k++)
      @(posedge mclk);
    if (cap_cnt == n)
    begin
      err_count++;
      $display("CHECK FAILED %0t no frame captured", $time);
    end
  endtask : wait_cap
  // Line bits: start, data, parity or multiprocessor bit, then ones
  function automatic logic [12:0] frame(input logic [7:0] x, input logic [7:0] m,
    input logic [7:0] f, input logic p, output int s);
    logic [12:0] r;
    logic [7:0] v;
    int nd;
    r = '1;
    r[0] = 1'b0;
    v = f[FMT_INV] ? ~x : x;
    nd = m[MODE_CHR7] ? 7 : 8;
    for (int i = 0; i < nd; i++)
      r[i + 1] = f[FMT_ORDER] ? v[nd - 1 - i] : v[i];
    s = nd + 1;
    if (m[MODE_MP] || m[MODE_PAR])
      r[s] = m[MODE_MP] ? p : (^(v & (m[MODE_CHR7] ? 8'h7F : 8'hFF))) ^ m[MODE_ODD];
    if (m[MODE_MP] || m[MODE_PAR])
      s++;
    return r;
  endfunction : frame
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, standby, wr, rd, ext_run, listen} = 6'h21;
    {addr, wdata} = '0;
    bit_cyc = 8'h10;
    void'($urandom(2287));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(ADDR_FMT, got);
    chk_reg(got, 8'hF2, "format reset");
    wr_rd(ADDR_FMT, 8'hFE, got);
    chk_reg(got, 8'hFE, "format write");
    wr_rd(ADDR_FMT, 8'h00, got);
    chk_reg(got, 8'hF2, "format fixed ones");
    wr_rd(3'h7, 8'h5A, got);
    chk_reg(got, 8'h00, "unmapped");
    wr_reg(ADDR_FMT, 8'hFC);
    standby <= 1'b1;
    @(posedge mclk);
    addr <= ADDR_FMT;
    rd <= 1'b1;
    @(posedge mclk);
    {rd, standby} <= 2'b00;
    #1 chk_reg(rdata, 8'hF2, "standby reset");
    for (int k = 0; k < 8; k++)
    begin
      cfg({k[2], 7'h00}, 8'hF2, {6'h00, k[1:0]});
      chk_reg({7'h00, sck_oe}, {7'h00, !k[1] && (k[2] || k[0])}, "clock pin");
    end
    listen = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      md = {1'b0, i[2], i[3], 1'($urandom), 1'($urandom), 1'($urandom), 2'b00};
      fm = {4'hF, i[0], i[1], 2'b10};
      mpb = 1'($urandom);
      d = (i < 2) ? {8{i[0]}} : 8'($urandom);
      cfg(md, fm, 8'h20);
      wr_reg(ADDR_STAT, {7'h00, mpb});
      n0 = cap_cnt;
      wr_reg(ADDR_TXH, d);
      wait_cap(n0);
      chk_line(cap_bits, frame(d, md, fm, mpb, sp), "tx frame");
    end
    for (int i = 0; i < 10; i++)
    begin
      e = i % 5;
      md = {1'b0, 1'($urandom), (e == 1) | 1'($urandom), 2'($urandom), (e != 1) & 1'($urandom), 2'b00};
      fm = {4'hF, 2'($urandom), 2'b10};
      d = {6'($urandom), 2'b01};
      cfg(md, fm, 8'h10);
      b = frame(d, md, fm, 1'b0, sp);
      if (e == 1)
        b[sp - 1] = ~b[sp - 1];
      if (e == 2)
        b[sp] = 1'b0;
      if (e == 3)
        b = b & ~((13'h1 << (sp + 1)) - 13'h1);
      u_far.send(b);
      if (e == 4)
        u_far.send(frame(~d, md, fm, 1'b0, sp));
      rd_reg(ADDR_STAT, got);
      chk_reg(got & ((e % 4 == 0) ? 8'h78 : 8'h38), (e == 4) ? 8'h60 : (e == 0) ? 8'h40 :
        {3'h0, e > 1, e != 2, 3'h0}, "rx status");
      rd_reg(ADDR_RXH, got);
      if (e % 4 == 0)
        chk_reg(got, d & (md[MODE_CHR7] ? 8'h7F : 8'hFF), "rx data");
      wr_reg(ADDR_STAT, 8'h78);
    end
    cfg(8'h00, 8'hF2, 8'h22);
    {bit_cyc, ext_run} = {8'h20, 1'b1};
    chk_reg({7'h00, sck_oe}, 8'h00, "external clock pin");
    d = 8'($urandom);
    n0 = cap_cnt;
    wr_reg(ADDR_TXH, d);
    wait_cap(n0);
    chk_line(cap_bits, frame(d, 8'h00, 8'hF2, 1'b0, sp), "ext tx");
    {bit_cyc, ext_run, listen} = {8'h10, 2'b00};
    for (int i = 0; i < 2; i++)
    begin
      fm = {4'hF, i[0], 1'($urandom), 2'b10};
      cfg(8'h80, fm, 8'h30);
      d = 8'($urandom);
      wr_reg(ADDR_TXH, d);
      {n0, prev, cap} = {32'h0, 1'b1, 13'h1FFE};
      repeat (100)
      begin
        @(posedge mclk);
        #1;
        if (sck_out && !prev && n0 < 12)
          cap[n0 + 1] = txd;
        n0 += (sck_out && !prev);
        prev = sck_out;
      end
      chk_reg(8'(n0), 8'h08, "sync clocks");
      chk_line(cap, frame(d, 8'h00, fm, 1'b0, sp), "sync bits");
      rd_reg(ADDR_STAT, got);
      chk_reg(got & 8'h78, (i == 0) ? 8'h40 : 8'h60, "sync rx status");
      rd_reg(ADDR_RXH, got);
      if (i == 0)
        chk_reg(got, fm[FMT_INV] ? 8'h00 : 8'hFF, "sync rx data");
    end
    report_and_stop();
  end
endmodule : sfm_serial_format_tb
